//--- design/scs_pkg.sv
/*
  Constants, field layouts and carrier types of the sample clock source
  selector. Assumes a 32-bit AXI4-Lite master and a 20 MHz system clock.
*/
package scs_pkg;

  // ----------------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 18;
  localparam int WORD_W = ADDR_W - 2;

  // register indexes; byte address is four times the index
  localparam logic [WORD_W-1:0] IDX_SOURCE_SELECT = 16'h4ee8;
  localparam logic [WORD_W-1:0] IDX_SUPPORTED     = 16'h4ee9;
  localparam logic [WORD_W-1:0] IDX_CONFIG        = 16'h4eea;
  localparam logic [WORD_W-1:0] IDX_STATUS        = 16'h4eeb;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------------
  // mode codes, one bit each
  // ----------------------------------------------------------------------
  localparam int MODE_W = 6;
  localparam logic [MODE_W-1:0] MODE_INTERNAL_PLL        = 6'h01;
  localparam logic [MODE_W-1:0] MODE_FIRST_CRYSTAL       = 6'h02;
  localparam logic [MODE_W-1:0] MODE_SECOND_CRYSTAL      = 6'h04;
  localparam logic [MODE_W-1:0] MODE_DIRECT_OUTSIDE      = 6'h08;
  localparam logic [MODE_W-1:0] MODE_DIVIDED_OUTSIDE     = 6'h10;
  localparam logic [MODE_W-1:0] MODE_PLL_OUTSIDE_REF     = 6'h20;
  localparam logic [MODE_W-1:0] MODE_RESET               = 6'h01;
  localparam logic [MODE_W-1:0] AVAIL_BASE               = 6'h3b;
  localparam int                SECOND_CRYSTAL_BIT       = 2;

  // internal pll reference frequency
  localparam int INTERNAL_REF_MHZ = 10;

  // ----------------------------------------------------------------------
  // pins and divider sources
  // ----------------------------------------------------------------------
  localparam int PIN_N          = 7;
  localparam int PIN_FIRST_Q    = 0;
  localparam int PIN_SECOND_Q   = 1;
  localparam int PIN_OUTSIDE    = 2;
  localparam int PIN_SYNC       = 3;
  localparam int PIN_PLL        = 4;
  localparam int PIN_Q2_FITTED  = 5;
  localparam int PIN_HUB_FITTED = 6;
  localparam int MAX_CARDS      = 16;

  // ----------------------------------------------------------------------
  // config register fields
  // ----------------------------------------------------------------------
  localparam int DIV_W         = 16;
  localparam int CFG_RATIO_LSB = 0;
  localparam int CFG_Q2USE_LSB = 16;
  localparam int CFG_HUB_BIT   = 18;
  localparam int CFG_SLOT_LSB  = 20;
  localparam logic [DIV_W-1:0] RATIO_RESET = 16'h0001;

  localparam logic [1:0] Q2_DIRECT  = 2'h0;
  localparam logic [1:0] Q2_DIVIDED = 2'h1;
  localparam logic [1:0] Q2_PLL_REF = 2'h2;

  // status register fields
  localparam int ST_REJECT_BIT = 0;
  localparam int ST_PLL_BIT    = 1;
  localparam int ST_DIV_BIT    = 2;
  localparam int ST_SRC_LSB    = 4;
  localparam int ST_HUB_BIT    = 8;
  localparam int ST_Q2_BIT     = 9;

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } scs_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } scs_axi_rsp_t;

  typedef struct packed {
    logic       pll_enable;
    logic       pll_ref_outside;
    logic       pll_ref_second_crystal;
    logic [2:0] divider_source;
    logic       divider_active;
  } scs_route_t;

endpackage

//--- design/scs_clock_select.sv
/*
  Sample clock source selector: mode register, availability mask, routing
  of pll reference and divider input, and the sample tick divider.
  Assumes an AXI4-Lite master on clk, clock pins that toggle slower than
  clk/4 once sampled, and option straps that are static.
*/
// Contract
// - writable mode register reads back selection
// - read-only mask flags each supported mode
// - codes 1,2,4 pick pll, crystals
// - codes 8,16,32 pick outside clock modes
// - default mode: pll on internal reference
// - first crystal always passes the divider
// - second crystal direct, divided or reference
// - outside reference 1 to 125 MHz
// - direct outside clock passes unmodified
// - divided outside clock passes the divider
// - hub clock feeds divider, sixteen cards
`timescale 1ns/1ps

module scs_clock_select (
  input  wire logic                       clk,
  input  wire logic                       ce,
  input  wire logic                       srst,
  input  wire scs_pkg::scs_axi_req_t      axi_req,
  output scs_pkg::scs_axi_rsp_t           axi_rsp,
  input  wire logic [scs_pkg::PIN_N-1:0]  pin_in,
  output scs_pkg::scs_route_t             route,
  output logic [scs_pkg::MODE_W-1:0]      active_mode,
  output logic                            sample_tick
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [scs_pkg::PIN_N-1:0]  sync_a;
    logic [scs_pkg::PIN_N-1:0]  sync_b;
    logic [scs_pkg::PIN_N-1:0]  sync_c;
    logic [scs_pkg::PIN_N-1:0]  level;
    logic [scs_pkg::MODE_W-1:0] mode;
    logic [scs_pkg::MODE_W-1:0] avail;
    logic [scs_pkg::DIV_W-1:0]  ratio;
    logic [1:0]                 q2_use;
    logic                       hub_sync;
    logic [3:0]                 card_slot;
    logic                       reject;
    logic [scs_pkg::DIV_W-1:0]  div_count;
    logic                       tick;
    scs_pkg::scs_route_t        rt;
    logic                       aw_held;
    logic [scs_pkg::WORD_W-1:0] aw_word;
    logic                       w_held;
    logic [31:0]                w_data;
    logic [3:0]                 w_strb;
    scs_pkg::scs_axi_rsp_t      rsp;
  } scs_state_t;

  scs_state_t s;
  scs_state_t next_s;

  logic [scs_pkg::PIN_N-1:0] rise;
  scs_pkg::scs_route_t       want_rt;

  // ----------------------------------------------------------------------
  // pin edge detection
  // ----------------------------------------------------------------------
  // a rising edge counts once the second and third stage agree on a new high level
  genvar gi;
  generate
    for (gi = 0; gi < scs_pkg::PIN_N; gi = gi + 1) begin : g_edge
      assign rise[gi] = s.sync_b[gi] & s.sync_c[gi] & ~s.level[gi];
    end
  endgenerate

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] cfg_word(input scs_state_t st);
    logic [31:0] r;
    r = 32'h0;
    r[scs_pkg::CFG_RATIO_LSB +: scs_pkg::DIV_W] = st.ratio;
    r[scs_pkg::CFG_Q2USE_LSB +: 2] = st.q2_use;
    r[scs_pkg::CFG_HUB_BIT] = st.hub_sync;
    r[scs_pkg::CFG_SLOT_LSB +: 4] = st.card_slot;
    return r;
  endfunction

  function automatic logic [31:0] status_word(input scs_state_t st);
    logic [31:0] r;
    r = 32'h0;
    r[scs_pkg::ST_REJECT_BIT] = st.reject;
    r[scs_pkg::ST_PLL_BIT] = st.rt.pll_enable;
    r[scs_pkg::ST_DIV_BIT] = st.rt.divider_active;
    r[scs_pkg::ST_SRC_LSB +: 3] = st.rt.divider_source;
    r[scs_pkg::ST_HUB_BIT] = st.level[scs_pkg::PIN_HUB_FITTED];
    r[scs_pkg::ST_Q2_BIT] = st.level[scs_pkg::PIN_Q2_FITTED];
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // source routing per mode
  // ----------------------------------------------------------------------
  always_comb begin
    logic hub_on;
    hub_on = s.hub_sync & s.level[scs_pkg::PIN_HUB_FITTED];
    want_rt = '0;
    case (s.mode)
      scs_pkg::MODE_INTERNAL_PLL: begin
        want_rt.pll_enable = 1'b1;
        want_rt.divider_source = 3'(scs_pkg::PIN_PLL);
        want_rt.divider_active = 1'b1;
      end
      scs_pkg::MODE_FIRST_CRYSTAL: begin
        want_rt.divider_source = 3'(scs_pkg::PIN_FIRST_Q);
        want_rt.divider_active = 1'b1;
      end
      scs_pkg::MODE_SECOND_CRYSTAL: begin
        if (s.q2_use == scs_pkg::Q2_PLL_REF) begin
          want_rt.pll_enable = 1'b1;
          want_rt.pll_ref_second_crystal = 1'b1;
          want_rt.divider_source = 3'(scs_pkg::PIN_PLL);
          want_rt.divider_active = 1'b1;
        end else begin
          want_rt.divider_source = 3'(scs_pkg::PIN_SECOND_Q);
          want_rt.divider_active = (s.q2_use == scs_pkg::Q2_DIVIDED);
        end
      end
      scs_pkg::MODE_DIRECT_OUTSIDE: begin
        want_rt.divider_source = 3'(scs_pkg::PIN_OUTSIDE);
        want_rt.divider_active = 1'b0;
      end
      scs_pkg::MODE_DIVIDED_OUTSIDE: begin
        want_rt.divider_source = 3'(scs_pkg::PIN_OUTSIDE);
        want_rt.divider_active = 1'b1;
      end
      scs_pkg::MODE_PLL_OUTSIDE_REF: begin
        want_rt.pll_enable = 1'b1;
        want_rt.pll_ref_outside = 1'b1;
        want_rt.divider_source = 3'(scs_pkg::PIN_PLL);
        want_rt.divider_active = 1'b1;
      end
      default: begin
        want_rt.pll_enable = 1'b1;
        want_rt.divider_source = 3'(scs_pkg::PIN_PLL);
        want_rt.divider_active = 1'b1;
      end
    endcase
    if (hub_on && want_rt.divider_active && !want_rt.pll_enable) begin
      want_rt.divider_source = 3'(scs_pkg::PIN_SYNC);
    end
  end

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic [31:0] wv;
    logic [31:0] cur;
    logic        mode_changed;
    logic        sel_rise;
    next_s = s;
    wv = 32'h0;
    cur = 32'h0;
    mode_changed = 1'b0;
    sel_rise = 1'b0;

    // three-stage sampling of pins and straps
    next_s.sync_a = pin_in;
    next_s.sync_b = s.sync_a;
    next_s.sync_c = s.sync_b;
    for (int i = 0; i < scs_pkg::PIN_N; i++) begin
      if (s.sync_b[i] == s.sync_c[i]) begin
        next_s.level[i] = s.sync_c[i];
      end
    end

    // write address and data taken in either order
    if (axi_req.awvalid && s.rsp.awready) begin
      next_s.aw_held = 1'b1;
      next_s.aw_word = axi_req.awaddr[scs_pkg::ADDR_W-1:2];
    end
    if (axi_req.wvalid && s.rsp.wready) begin
      next_s.w_held = 1'b1;
      next_s.w_data = axi_req.wdata;
      next_s.w_strb = axi_req.wstrb;
    end
    if (s.rsp.bvalid && axi_req.bready) begin
      next_s.rsp.bvalid = 1'b0;
    end

    if (s.aw_held && s.w_held && !s.rsp.bvalid) begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.rsp.bvalid = 1'b1;
      next_s.rsp.bresp = scs_pkg::RESP_OKAY;
      case (s.aw_word)
        scs_pkg::IDX_SOURCE_SELECT: begin
          cur = {26'h0, s.mode};
          wv = merge(cur, s.w_data, s.w_strb);
          if ($onehot(wv[scs_pkg::MODE_W-1:0]) && wv[31:scs_pkg::MODE_W] == 26'h0
              && (wv[scs_pkg::MODE_W-1:0] & ~s.avail) == 6'h00) begin
            next_s.mode = wv[scs_pkg::MODE_W-1:0];
            mode_changed = 1'b1;
          end else begin
            next_s.reject = 1'b1;
            next_s.rsp.bresp = scs_pkg::RESP_SLVERR;
          end
        end
        scs_pkg::IDX_SUPPORTED: begin
          // read-only, write ignored
        end
        scs_pkg::IDX_CONFIG: begin
          wv = merge(cfg_word(s), s.w_data, s.w_strb);
          // ratio zero behaves as one
          next_s.ratio = (wv[scs_pkg::CFG_RATIO_LSB +: scs_pkg::DIV_W] == 16'h0000) ?
                         scs_pkg::RATIO_RESET : wv[scs_pkg::CFG_RATIO_LSB +: scs_pkg::DIV_W];
          next_s.q2_use = (wv[scs_pkg::CFG_Q2USE_LSB +: 2] == 2'h3) ?
                          s.q2_use : wv[scs_pkg::CFG_Q2USE_LSB +: 2];
          next_s.hub_sync = wv[scs_pkg::CFG_HUB_BIT];
          next_s.card_slot = wv[scs_pkg::CFG_SLOT_LSB +: 4];
          mode_changed = 1'b1;
        end
        scs_pkg::IDX_STATUS: begin
          // write one clears the reject flag
          if (s.w_strb[0] && s.w_data[scs_pkg::ST_REJECT_BIT]) begin
            next_s.reject = 1'b0;
          end
        end
        default: begin
          next_s.rsp.bresp = scs_pkg::RESP_SLVERR;
        end
      endcase
    end

    // read channel
    if (s.rsp.rvalid && axi_req.rready) begin
      next_s.rsp.rvalid = 1'b0;
    end
    if (axi_req.arvalid && s.rsp.arready) begin
      next_s.rsp.rvalid = 1'b1;
      next_s.rsp.rresp = scs_pkg::RESP_OKAY;
      case (axi_req.araddr[scs_pkg::ADDR_W-1:2])
        scs_pkg::IDX_SOURCE_SELECT: next_s.rsp.rdata = {26'h0, s.mode};
        scs_pkg::IDX_SUPPORTED: next_s.rsp.rdata = {26'h0, s.avail};
        scs_pkg::IDX_CONFIG: next_s.rsp.rdata = cfg_word(s);
        scs_pkg::IDX_STATUS: next_s.rsp.rdata = status_word(s);
        default: begin
          next_s.rsp.rdata = 32'h0;
          next_s.rsp.rresp = scs_pkg::RESP_SLVERR;
        end
      endcase
    end

    // route follows the mode one cycle later
    next_s.rt = want_rt;

    // divider on the selected source's rising edges
    sel_rise = rise[s.rt.divider_source];
    next_s.tick = 1'b0;
    if (mode_changed || want_rt != s.rt) begin
      // restart so the first period after a switch is whole
      next_s.div_count = '0;
    end else if (sel_rise) begin
      if (!s.rt.divider_active || (s.div_count + 16'h0001) >= s.ratio) begin
        next_s.tick = 1'b1;
        next_s.div_count = '0;
      end else begin
        next_s.div_count = s.div_count + 16'h0001;
      end
    end

    // one held item per channel at a time
    next_s.rsp.awready = !next_s.aw_held && !next_s.rsp.bvalid;
    next_s.rsp.wready = !next_s.w_held && !next_s.rsp.bvalid;
    next_s.rsp.arready = !next_s.rsp.rvalid;

    if (srst) begin
      // sampling stages keep running so straps are seen at release
      next_s.mode = scs_pkg::MODE_RESET;
      next_s.avail = scs_pkg::AVAIL_BASE;
      next_s.avail[scs_pkg::SECOND_CRYSTAL_BIT] = s.level[scs_pkg::PIN_Q2_FITTED];
      next_s.ratio = scs_pkg::RATIO_RESET;
      next_s.q2_use = scs_pkg::Q2_DIRECT;
      next_s.hub_sync = 1'b0;
      next_s.card_slot = 4'h0;
      next_s.reject = 1'b0;
      next_s.div_count = '0;
      next_s.tick = 1'b0;
      next_s.rt = '0;
      next_s.aw_held = 1'b0;
      next_s.aw_word = '0;
      next_s.w_held = 1'b0;
      next_s.w_data = 32'h0;
      next_s.w_strb = 4'h0;
      next_s.rsp = '0;
    end
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (ce) begin
      s <= next_s;
    end
  end

  assign axi_rsp = s.rsp;
  assign route = s.rt;
  assign active_mode = s.mode;
  assign sample_tick = s.tick;

endmodule // scs_clock_select

//--- dv/scs_clock_source_model.sv
/*
  Far-side clock sources: crystals, outside clock, hub sync, pll output
  and option straps. Assumes every pin is sampled by a 20 MHz clk.
*/
`timescale 1ns/1ps

module scs_clock_source_model (
  input  wire logic                      q2_fitted,
  input  wire logic                      hub_fitted,
  output logic [scs_pkg::PIN_N-1:0]      pins
);
  logic [4:0] ck = 5'h00;

  // all sources free-run, slower than clk/4
  always #200 ck[0] = ~ck[0];
  always #300 ck[1] = ~ck[1];
  always #500 ck[2] = ~ck[2];
  always #400 ck[3] = ~ck[3];
  always #250 ck[4] = ~ck[4];

  assign pins = {hub_fitted, q2_fitted, ck};
endmodule // scs_clock_source_model

//--- dv/scs_clock_select_monitor.sv
/*
  Checker of the sample clock source selector, bound to its top module.
  Assumes ce held high.
*/
`timescale 1ns/1ps

module scs_clock_select_monitor (
  input wire logic                       clk,
  input wire logic                       ce,
  input wire logic                       srst,
  input wire scs_pkg::scs_axi_req_t      axi_req,
  input wire scs_pkg::scs_axi_rsp_t      axi_rsp,
  input wire logic [scs_pkg::PIN_N-1:0]  pin_in,
  input wire scs_pkg::scs_route_t        route,
  input wire logic [scs_pkg::MODE_W-1:0] active_mode,
  input wire logic                       sample_tick
);
  logic [3:0] since_wr;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // age of last address handshake; mode may only move shortly after one
  always_ff @(posedge clk) begin
    if (srst) since_wr <= 4'hf;
    else if (axi_req.awvalid && axi_rsp.awready) since_wr <= 4'h0;
    else if (since_wr != 4'hf) since_wr <= since_wr + 4'h1;
  end

  a_reset_route:
    assert property ($fell(srst) |-> ##[1:2] (route.pll_enable && route.divider_source == 3'h4
      && active_mode == scs_pkg::MODE_RESET)) else $error("pll route or mode wrong after reset");
  a_mode_onehot:
    assert property ($onehot(active_mode)) else $error("active mode not one-hot");
  a_mode_held:
    assert property ($changed(active_mode) |-> since_wr < 4'h4) else $error("mode moved without write");
  a_write_resp:
    assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready
      |-> ##[1:2] axi_rsp.bvalid) else $error("write response late");
  a_read_resp:
    assert property (axi_req.arvalid && axi_rsp.arready |-> ##[1:2] axi_rsp.rvalid) else $error("read late");
  a_rdata_hold:
    assert property (axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
      else $error("read data dropped before ready");
  // three cycles: the route still shows its reset value one edge after release
  a_pll_internal:
    assert property ((active_mode == scs_pkg::MODE_INTERNAL_PLL) [*3] |-> route.pll_enable
      && !route.pll_ref_outside && !route.pll_ref_second_crystal) else $error("internal pll route wrong");
  a_first_crystal:
    assert property ((active_mode == scs_pkg::MODE_FIRST_CRYSTAL) [*2] |-> route.divider_active
      && !route.pll_enable && route.divider_source == 3'h0) else $error("crystal not through divider");
  a_direct_clock:
    assert property ((active_mode == scs_pkg::MODE_DIRECT_OUTSIDE) [*2] |-> !route.pll_enable)
      else $error("direct clock through pll");
  a_divided_clock:
    assert property ((active_mode == scs_pkg::MODE_DIVIDED_OUTSIDE) [*2] |-> route.divider_active
      && !route.pll_enable && (route.divider_source == 3'h2 || route.divider_source == 3'h3))
      else $error("outside clock not divided");
  a_pll_outside:
    assert property ((active_mode == scs_pkg::MODE_PLL_OUTSIDE_REF) [*2] |-> route.pll_enable
      && route.pll_ref_outside) else $error("pll not on outside reference");

  c_reject: cover property (axi_rsp.bvalid && axi_rsp.bresp == scs_pkg::RESP_SLVERR);
  c_outside_ref: cover property (active_mode == scs_pkg::MODE_PLL_OUTSIDE_REF);
  c_hub_tick: cover property (sample_tick && route.divider_source == 3'h3);
endmodule // scs_clock_select_monitor

bind scs_clock_select scs_clock_select_monitor u_mon (
  .clk(clk), .ce(ce), .srst(srst), .axi_req(axi_req), .axi_rsp(axi_rsp), .pin_in(pin_in),
  .route(route), .active_mode(active_mode), .sample_tick(sample_tick));

//--- dv/test_sample_clock_source_select.sv
/*
  Self-checking bench of the sample clock source selector over AXI4-Lite.
  Assumes the source model of the clock pins; ce held high.
*/
`timescale 1ns/1ps

module test_sample_clock_source_select;
  localparam logic [15:0] SEL = scs_pkg::IDX_SOURCE_SELECT;
  localparam logic [15:0] MSK = scs_pkg::IDX_SUPPORTED;
  localparam logic [15:0] CFG = scs_pkg::IDX_CONFIG;
  localparam logic [15:0] STA = scs_pkg::IDX_STATUS;
  localparam logic [1:0]  OK  = scs_pkg::RESP_OKAY;
  localparam logic [1:0]  ERR = scs_pkg::RESP_SLVERR;

  logic                       clk    = 1'b0;
  logic                       srst   = 1'b1;
  logic                       ce     = 1'b1;
  logic                       q2_fit = 1'b0;
  logic                       hub_fit = 1'b1;
  scs_pkg::scs_axi_req_t      req    = '0;
  scs_pkg::scs_axi_rsp_t      rsp;
  logic [scs_pkg::PIN_N-1:0]  pins;
  scs_pkg::scs_route_t        route;
  logic [scs_pkg::MODE_W-1:0] mode;
  logic                       tick;
  logic [33:0]                rq[$];
  logic [1:0]                 bq[$];
  logic [31:0]                cfg;
  int                         err_total = 0;
  int                         checks_done = 0;
  int                         r;
  int                         s;

  always #25 clk = ~clk;

  scs_clock_source_model u_src (.q2_fitted(q2_fit), .hub_fitted(hub_fit), .pins(pins));

  scs_clock_select DUT (.clk(clk), .ce(ce), .srst(srst), .axi_req(req), .axi_rsp(rsp), .pin_in(pins),
    .route(route), .active_mode(mode), .sample_tick(tick));

  task automatic end_sim();
    if (err_total == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic hang();
    err_total++;
    end_sim();
  endtask

  task automatic rst(input logic q2);
    @(posedge clk);
    q2_fit <= q2;
    srst <= 1'b1;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic wr(input logic [15:0] idx, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge clk);
    bq.push_back(er);
    req.awaddr <= {idx, 2'b00};
    req.awvalid <= 1'b1;
    req.wdata <= d;
    req.wvalid <= 1'b1;
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid) break;
    end
    req.bready <= 1'b0;
    if (n == 40) hang();
  endtask

  // ready held back two edges so the slave must hold its answer
  task automatic rd(input logic [15:0] idx, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge clk);
    rq.push_back({er, d});
    req.araddr <= {idx, 2'b00};
    req.arvalid <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (rsp.arready) req.arvalid <= 1'b0;
      if (n == 2) req.rready <= 1'b1;
      if (rsp.rvalid && req.rready) break;
    end
    req.rready <= 1'b0;
    if (n == 40) hang();
  endtask

  // pin edges are resynchronised, so one tick of slack either way
  task automatic ticks(input int e);
    int c;
    c = 0;
    repeat (20) @(posedge clk);
    repeat (800) begin
      @(posedge clk);
      if (tick === 1'b1) c++;
    end
    checks_done++;
    if (c < e - 1 || c > e + 1) begin
      err_total++;
      $display("[ERR] ticks expected %0d seen %0d", e, c);
    end
  endtask

  always @(posedge clk) begin
    if (rsp.rvalid && req.rready && rq.size() > 0) chk("read", rq.pop_front(), {rsp.rresp, rsp.rdata});
    if (rsp.bvalid && req.bready && bq.size() > 0) chk("bresp", {32'h0, bq.pop_front()}, {32'h0, rsp.bresp});
  end

  initial begin
    void'($urandom(99282));
    r = 2 + ($urandom % 2);
    s = $urandom % 16;
    cfg = {8'h00, s[3:0], 4'h0, 16'(r)};
    rst(1'b0);
    rd(SEL, 32'h1, OK);
    rd(MSK, 32'h3b, OK);
    wr(SEL, 32'h4, ERR);
    rd(SEL, 32'h1, OK);
    // reject flag, pll route on pin 4, hub strap
    rd(STA, 32'h147, OK);
    wr(STA, 32'h1, OK);
    rd(STA, 32'h146, OK);
    rst(1'b1);
    rd(MSK, 32'h3f, OK);
    wr(MSK, 32'h0, OK);
    rd(MSK, 32'h3f, OK);
    for (int i = 0; i < 6; i++) begin
      wr(SEL, 32'h1 << i, OK);
      rd(SEL, 32'h1 << i, OK);
      chk("mode", 34'h1 << i, {28'h0, mode});
    end
    wr(SEL, 32'h3, ERR);
    wr(SEL, 32'h40, ERR);
    rd(SEL, 32'h20, OK);
    rd(16'h4ef0, 32'h0, ERR);
    wr(CFG, cfg, OK);
    rd(CFG, cfg, OK);
    wr(SEL, 32'h2, OK);
    ticks(100 / r);
    wr(SEL, 32'h8, OK);
    ticks(40);
    wr(SEL, 32'h10, OK);
    ticks(40 / r);
    wr(CFG, cfg | 32'h40000, OK);
    ticks(50 / r);
    chk("route", 34'h3, {31'h0, route.divider_source});
    // without the hub strap the enable alone must not reroute
    hub_fit <= 1'b0;
    repeat (10) @(posedge clk);
    chk("route", 34'h2, {31'h0, route.divider_source});
    wr(SEL, 32'h4, OK);
    wr(CFG, cfg | 32'h10000, OK);
    ticks(67 / r);
    wr(CFG, cfg | 32'h20000, OK);
    // second crystal as pll reference, reject still set from above
    rd(STA, 32'h247, OK);
    end_sim();
  end
endmodule // test_sample_clock_source_select
